// ---- src/lccr_regs.sv ----
// Configuration slice: three 8-bit registers and the logic they steer.
// Assumes register port and video inputs share the core clock; I2C pins are asynchronous.
// Functional notes
// - Back-channel CRC generated only while CRC enable bit 6 is one.
// - Filter enabled rejects sync and data-enable pulses shorter than two clocks.
// - Pass-through, pass-through-all and acknowledge select drive forwarding behaviour.
// - Edge select one strobes on rising edge, zero on falling edge.
// - Control channel transaction aborts after watchdog field times 2 ms.
// - Watchdog disable bit one suspends the watchdog.
// - SDA input held against SCL by field times 50 ns.
// - SCL and SDA glitches up to field times 5 ns rejected.
module lccr_regs #(
    parameter int WDOG_STEP_CYCLES = lccr_pkg::WDOG_STEP_CYC
) (
    input wire logic CORE_CLK_IN,
    input wire logic ARST_N_IN,
    input wire logic CLK_EN_IN,
    input wire logic REG_WR_IN,
    input wire logic REG_RD_IN,
    input wire logic [7:0] REG_ADDR_IN,
    input wire logic [7:0] REG_WDATA_IN,
    output logic [7:0] REG_RDATA_OUT,
    input wire logic HORIZONTAL_SYNC_IN,
    input wire logic VERTICAL_SYNC_IN,
    input wire logic VIDEO_DATA_ENABLE_IN,
    output logic HORIZONTAL_SYNC_OUT,
    output logic VERTICAL_SYNC_OUT,
    output logic VIDEO_DATA_ENABLE_OUT,
    input wire logic SCL_IN,
    input wire logic SDA_IN,
    output logic SCL_FILT_OUT,
    output logic SDA_FILT_OUT,
    input wire logic BIDIR_CONTROL_CHANNEL_START_IN,
    input wire logic BIDIR_CONTROL_CHANNEL_DONE_IN,
    output logic BIDIR_CONTROL_CHANNEL_BUSY_OUT,
    output logic BIDIR_CONTROL_CHANNEL_ABORT_OUT,
    output logic CRC_GEN_EN_OUT,
    output logic PASS_THROUGH_EN_OUT,
    output logic PASS_THROUGH_ALL_OUT,
    output logic AUTO_ACK_OUT,
    output logic PIXEL_STROBE_EDGE_SELECT_OUT
);
    ////////////////////////////////////////////////////////////////
    // Register storage and decode
    logic [7:0] cfg_one_q;
    logic [7:0] wdog_q;
    logic [7:0] sbc_one_q;
    logic sel_cfg;
    logic sel_wdog;
    logic sel_sbc;
    logic wr_cfg;
    logic wr_wdog;
    logic wr_sbc;
    logic [7:0] rdata_d;

    // Address decode, shared by write and read
    assign sel_cfg = REG_ADDR_IN == lccr_pkg::ADDR_CFG_ONE;
    assign sel_wdog = REG_ADDR_IN == lccr_pkg::ADDR_WDOG;
    assign sel_sbc = REG_ADDR_IN == lccr_pkg::ADDR_SBC_ONE;
    assign wr_cfg = REG_WR_IN && sel_cfg;
    assign wr_wdog = REG_WR_IN && sel_wdog;
    assign wr_sbc = REG_WR_IN && sel_sbc;
    assign rdata_d = sel_cfg ? cfg_one_q :
                     sel_wdog ? wdog_q :
                     sel_sbc ? sbc_one_q : 8'h00;

    always_ff @(posedge CORE_CLK_IN or negedge ARST_N_IN) begin
        if (!ARST_N_IN) begin
            cfg_one_q <= lccr_pkg::RST_CFG_ONE;
            wdog_q <= lccr_pkg::RST_WDOG;
            sbc_one_q <= lccr_pkg::RST_SBC_ONE;
            REG_RDATA_OUT <= 8'h00;
        end else if (CLK_EN_IN) begin
            if (wr_cfg) begin
                cfg_one_q <= (REG_WDATA_IN & lccr_pkg::CFG_ONE_WMASK)
                           | (lccr_pkg::RST_CFG_ONE & ~lccr_pkg::CFG_ONE_WMASK);
            end
            if (wr_wdog) begin
                wdog_q <= REG_WDATA_IN;
            end
            if (wr_sbc) begin
                sbc_one_q <= REG_WDATA_IN;
            end
            if (REG_RD_IN) begin
                REG_RDATA_OUT <= rdata_d;
            end
        end
    end

    ////////////////////////////////////////////////////////////////
    // Control outputs
    always_ff @(posedge CORE_CLK_IN or negedge ARST_N_IN) begin
        if (!ARST_N_IN) begin
            CRC_GEN_EN_OUT <= 1'b0;
            PASS_THROUGH_EN_OUT <= 1'b0;
            PASS_THROUGH_ALL_OUT <= 1'b0;
            AUTO_ACK_OUT <= 1'b0;
            PIXEL_STROBE_EDGE_SELECT_OUT <= 1'b0;
        end else if (CLK_EN_IN) begin
            CRC_GEN_EN_OUT <= cfg_one_q[lccr_pkg::CRC_EN_BIT];
            PASS_THROUGH_EN_OUT <= cfg_one_q[lccr_pkg::PASS_EN_BIT];
            PASS_THROUGH_ALL_OUT <= sbc_one_q[lccr_pkg::PASS_ALL_BIT];
            AUTO_ACK_OUT <= cfg_one_q[lccr_pkg::AUTO_ACK_BIT];
            PIXEL_STROBE_EDGE_SELECT_OUT <= cfg_one_q[lccr_pkg::EDGE_SEL_BIT];
        end
    end

    ////////////////////////////////////////////////////////////////
    // Video sync filters
    logic filt_bypass;
    logic [2:0] vid_raw;
    logic [2:0] vid_filt;

    assign filt_bypass = !cfg_one_q[lccr_pkg::FILT_EN_BIT];
    assign vid_raw = {HORIZONTAL_SYNC_IN, VERTICAL_SYNC_IN, VIDEO_DATA_ENABLE_IN};

    for (genvar i = 0; i < 3; i++) begin : g_vid
        lccr_pulse_filter u_filt (
            .clk_in(CORE_CLK_IN),
            .arst_n_in(ARST_N_IN),
            .ce_in(CLK_EN_IN),
            .bypass_in(filt_bypass),
            .min_cyc_in(8'(lccr_pkg::SYNC_FILT_CYC)),
            .sig_in(vid_raw[i]),
            .sig_out(vid_filt[i])
        );
    end
    assign HORIZONTAL_SYNC_OUT = vid_filt[2];
    assign VERTICAL_SYNC_OUT = vid_filt[1];
    assign VIDEO_DATA_ENABLE_OUT = vid_filt[0];

    ////////////////////////////////////////////////////////////////
    // Serial bus input conditioning
    logic [1:0] scl_sync_q;
    logic [1:0] sda_sync_q;
    logic [7:0] depth_cyc;
    logic [7:0] hold_cyc;
    logic sda_glitch_free;

    always_ff @(posedge CORE_CLK_IN or negedge ARST_N_IN) begin
        if (!ARST_N_IN) begin
            scl_sync_q <= 2'h3;
            sda_sync_q <= 2'h3;
        end else if (CLK_EN_IN) begin
            scl_sync_q <= {scl_sync_q[0], SCL_IN};
            sda_sync_q <= {sda_sync_q[0], SDA_IN};
        end
    end

    assign depth_cyc = 8'(sbc_one_q[lccr_pkg::DEPTH_LSB +: 4] * lccr_pkg::DEPTH_STEP_CYC + 1);
    assign hold_cyc = 8'(sbc_one_q[lccr_pkg::HOLD_LSB +: 3] * lccr_pkg::HOLD_STEP_CYC
                         + depth_cyc);

    lccr_pulse_filter u_scl (
        .clk_in(CORE_CLK_IN),
        .arst_n_in(ARST_N_IN),
        .ce_in(CLK_EN_IN),
        .bypass_in(1'b0),
        .min_cyc_in(depth_cyc),
        .sig_in(scl_sync_q[1]),
        .sig_out(SCL_FILT_OUT)
    );

    lccr_pulse_filter u_sda (
        .clk_in(CORE_CLK_IN),
        .arst_n_in(ARST_N_IN),
        .ce_in(CLK_EN_IN),
        .bypass_in(1'b0),
        .min_cyc_in(hold_cyc),
        .sig_in(sda_sync_q[1]),
        .sig_out(sda_glitch_free)
    );
    assign SDA_FILT_OUT = sda_glitch_free;

    ////////////////////////////////////////////////////////////////
    // Control channel watchdog
    logic [31:0] step_q;
    logic [6:0] units_q;
    logic wd_run;
    logic step_wrap;

    assign wd_run = BIDIR_CONTROL_CHANNEL_BUSY_OUT && !wdog_q[lccr_pkg::WDOG_DIS_BIT];
    assign step_wrap = step_q == 32'(WDOG_STEP_CYCLES - 1);

    always_ff @(posedge CORE_CLK_IN or negedge ARST_N_IN) begin
        if (!ARST_N_IN) begin
            step_q <= 32'h0;
            units_q <= 7'h00;
            BIDIR_CONTROL_CHANNEL_BUSY_OUT <= 1'b0;
            BIDIR_CONTROL_CHANNEL_ABORT_OUT <= 1'b0;
        end else if (CLK_EN_IN) begin
            BIDIR_CONTROL_CHANNEL_ABORT_OUT <= 1'b0;
            if (BIDIR_CONTROL_CHANNEL_START_IN) begin
                BIDIR_CONTROL_CHANNEL_BUSY_OUT <= 1'b1;
                step_q <= 32'h0;
                units_q <= 7'h00;
            end else if (BIDIR_CONTROL_CHANNEL_DONE_IN) begin
                BIDIR_CONTROL_CHANNEL_BUSY_OUT <= 1'b0;
            end else if (wd_run) begin
                step_q <= step_wrap ? 32'h0 : step_q + 32'h1;
                if (step_wrap) begin
                    units_q <= units_q + 7'h01;
                    if (units_q + 7'h01 >= wdog_q[lccr_pkg::WDOG_LSB +: 7]) begin
                        BIDIR_CONTROL_CHANNEL_ABORT_OUT <= 1'b1;
                        BIDIR_CONTROL_CHANNEL_BUSY_OUT <= 1'b0;
                    end
                end
            end
        end
    end
endmodule // lccr_regs

// ---- src/lccr_pkg.sv ----
// Package: register map, field positions, reset values and timing of the config slice.
// Assumes a single 125 MHz core clock.
package lccr_pkg;
    // Register offsets
    localparam logic [7:0] ADDR_CFG_ONE = 8'h03;
    localparam logic [7:0] ADDR_WDOG = 8'h04;
    localparam logic [7:0] ADDR_SBC_ONE = 8'h05;
    // Reset values
    localparam logic [7:0] RST_CFG_ONE = 8'hF0;
    localparam logic [7:0] RST_WDOG = 8'hFE;
    localparam logic [7:0] RST_SBC_ONE = 8'h2E;
    // Writable bits of the first configuration register
    localparam logic [7:0] CFG_ONE_WMASK = 8'h5D;
    // Field positions
    localparam int CRC_EN_BIT = 6;
    localparam int FILT_EN_BIT = 4;
    localparam int PASS_EN_BIT = 3;
    localparam int AUTO_ACK_BIT = 2;
    localparam int EDGE_SEL_BIT = 0;
    localparam int WDOG_DIS_BIT = 0;
    localparam int WDOG_LSB = 1;
    localparam int PASS_ALL_BIT = 7;
    localparam int HOLD_LSB = 4;
    localparam int DEPTH_LSB = 0;
    // Timing
    localparam int CLK_MHZ = 125;
    localparam int CLK_PERIOD_PS = 8000;
    localparam int WDOG_STEP_MS = 2;
    localparam int WDOG_STEP_CYC = WDOG_STEP_MS * CLK_MHZ * 1000;
    localparam int HOLD_STEP_NS = 50;
    localparam int HOLD_STEP_CYC = (HOLD_STEP_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int DEPTH_STEP_NS = 5;
    localparam int DEPTH_STEP_CYC = (DEPTH_STEP_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int SYNC_FILT_CYC = 2;
endpackage

// ---- src/lccr_pulse_filter.sv ----
// Pulse filter: unless bypassed, output follows input only after it stands a set number of cycles.
// Assumes the input is already synchronous to the clock.
module lccr_pulse_filter (
    input wire logic clk_in,
    input wire logic arst_n_in,
    input wire logic ce_in,
    input wire logic bypass_in,
    input wire logic [7:0] min_cyc_in,
    input wire logic sig_in,
    output logic sig_out
);
    logic [7:0] cnt_q;
    logic [7:0] cnt_d;
    logic sig_d;
    logic differs;

    assign differs = sig_in != sig_out;
    assign cnt_d = differs ? cnt_q + 8'h01 : 8'h00;
    assign sig_d = bypass_in ? sig_in : ((differs && (cnt_d >= min_cyc_in)) ? sig_in : sig_out);

    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            cnt_q <= 8'h00;
            sig_out <= 1'b0;
        end else if (ce_in) begin
            cnt_q <= (sig_d == sig_in) ? 8'h00 : cnt_d;
            sig_out <= sig_d;
        end
    end
endmodule // lccr_pulse_filter

// ---- tb/lccr_sva.sv ----
// Checker: port-level assertions for the config slice.
// Assumes one clock domain and an asynchronous active-low reset.
module lccr_sva #(
    parameter int WDOG_STEP_CYCLES = 10
) (
    input wire logic CORE_CLK_IN,
    input wire logic ARST_N_IN,
    input wire logic CLK_EN_IN,
    input wire logic REG_WR_IN,
    input wire logic REG_RD_IN,
    input wire logic [7:0] REG_ADDR_IN,
    input wire logic [7:0] REG_WDATA_IN,
    input wire logic [7:0] REG_RDATA_OUT,
    input wire logic HORIZONTAL_SYNC_IN,
    input wire logic HORIZONTAL_SYNC_OUT,
    input wire logic BIDIR_CONTROL_CHANNEL_START_IN,
    input wire logic BIDIR_CONTROL_CHANNEL_DONE_IN,
    input wire logic BIDIR_CONTROL_CHANNEL_BUSY_OUT,
    input wire logic BIDIR_CONTROL_CHANNEL_ABORT_OUT,
    input wire logic CRC_GEN_EN_OUT,
    input wire logic PASS_THROUGH_EN_OUT,
    input wire logic AUTO_ACK_OUT,
    input wire logic PIXEL_STROBE_EDGE_SELECT_OUT
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge CORE_CLK_IN); endclocking
    default disable iff (!ARST_N_IN);
    wire rd_en = CLK_EN_IN && REG_RD_IN;
    wire wr3 = CLK_EN_IN && REG_WR_IN && REG_ADDR_IN == 8'h03;
    wire busy = BIDIR_CONTROL_CHANNEL_BUSY_OUT;
    wire abort = BIDIR_CONTROL_CHANNEL_ABORT_OUT;
    ////////////////////////////////////////////////////////////////////////////////
    property p_rd_unmapped;
        rd_en && !(REG_ADDR_IN inside {8'h03, 8'h04, 8'h05}) |=> REG_RDATA_OUT == 8'h00;
    endproperty
    a_rd_unmapped: assert property (p_rd_unmapped) else $error("unmapped read not zero");
    property p_rsv;
        rd_en && REG_ADDR_IN == 8'h03 |=> REG_RDATA_OUT[7] && REG_RDATA_OUT[5] && !REG_RDATA_OUT[1];
    endproperty
    a_rsv: assert property (p_rsv) else $error("reserved bits wrong");
    property p_crc;
        wr3 |-> ##2 CRC_GEN_EN_OUT == $past(REG_WDATA_IN[6], 2);
    endproperty
    a_crc: assert property (p_crc) else $error("crc enable out wrong");
    property p_pass;
        wr3 |-> ##2 {PASS_THROUGH_EN_OUT, AUTO_ACK_OUT} == $past(REG_WDATA_IN[3:2], 2);
    endproperty
    a_pass: assert property (p_pass) else $error("pass or ack out wrong");
    property p_edge;
        wr3 |-> ##2 PIXEL_STROBE_EDGE_SELECT_OUT == $past(REG_WDATA_IN[0], 2);
    endproperty
    a_edge: assert property (p_edge) else $error("edge select out wrong");
    property p_filt;
        $changed(HORIZONTAL_SYNC_OUT) |-> HORIZONTAL_SYNC_OUT == $past(HORIZONTAL_SYNC_IN);
    endproperty
    a_filt: assert property (p_filt) else $error("sync out moved without cause");
    property p_start;
        CLK_EN_IN && BIDIR_CONTROL_CHANNEL_START_IN |=> busy;
    endproperty
    a_start: assert property (p_start) else $error("busy not set");
    property p_abort;
        abort |-> $past(busy) ##1 !abort && !busy;
    endproperty
    a_abort: assert property (p_abort) else $error("abort not a single pulse");
    property p_done;
        CLK_EN_IN && BIDIR_CONTROL_CHANNEL_DONE_IN && !BIDIR_CONTROL_CHANNEL_START_IN |=> !busy;
    endproperty
    a_done: assert property (p_done) else $error("busy not cleared");
    c_wr3: cover property (wr3);
    c_abort: cover property (abort);
    c_sync: cover property ($rose(HORIZONTAL_SYNC_OUT));
endmodule // lccr_sva

bind lccr_regs lccr_sva #(.WDOG_STEP_CYCLES(WDOG_STEP_CYCLES)) u_sva (.*);

// ---- tb/lccr_link_model.sv ----
// Remote link model: start pulse, then done after a latency.
// Assumes the caller raises go_in off the clock edge.
module lccr_link_model (
    input wire logic clk_in,
    input wire logic go_in,
    input wire logic [7:0] lat_in,
    output logic start_out,
    output logic done_out
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        start_out = 1'b0;
        done_out = 1'b0;
    end
    // Latency zero never answers
    always @(posedge go_in) begin
        @(negedge clk_in) start_out = 1'b1;
        @(negedge clk_in) start_out = 1'b0;
        if (lat_in != 8'h00) begin
            repeat (lat_in) @(negedge clk_in);
            done_out = 1'b1;
            @(negedge clk_in) done_out = 1'b0;
        end
    end
endmodule // lccr_link_model

// ---- tb/tb_top.sv ----
// Testbench: register, filter and watchdog checks of the config slice.
// Assumes a shortened watchdog step of 10 cycles.
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 0, rst_n = 0, wr = 0, rd = 0, go = 0, ce = 1;
    logic [2:0] st = 0;
    logic [4:0] seen = 0;
    logic [7:0] addr = 0, wd = 0, lat = 0, d;
    logic [7:0] regs [3:5];
    wire [7:0] rdata;
    wire hs_o, vs_o, de_o, scl_f, sda_f, busy, abort, crc, pen, pall, ack, edg, start, done;
    int mismatches = 0, tests_run = 0, i, n;
    always #4 clk = ~clk;
    lccr_regs #(.WDOG_STEP_CYCLES(10)) uut (.CORE_CLK_IN(clk), .ARST_N_IN(rst_n),
        .CLK_EN_IN(ce), .REG_WR_IN(wr), .REG_RD_IN(rd), .REG_ADDR_IN(addr),
        .REG_WDATA_IN(wd), .REG_RDATA_OUT(rdata), .HORIZONTAL_SYNC_IN(st[0]),
        .VERTICAL_SYNC_IN(st[0]), .VIDEO_DATA_ENABLE_IN(st[0]), .HORIZONTAL_SYNC_OUT(hs_o),
        .VERTICAL_SYNC_OUT(vs_o), .VIDEO_DATA_ENABLE_OUT(de_o), .SCL_IN(~st[1]),
        .SDA_IN(~st[2]),
        .SCL_FILT_OUT(scl_f), .SDA_FILT_OUT(sda_f), .BIDIR_CONTROL_CHANNEL_START_IN(start),
        .BIDIR_CONTROL_CHANNEL_DONE_IN(done), .BIDIR_CONTROL_CHANNEL_BUSY_OUT(busy),
        .BIDIR_CONTROL_CHANNEL_ABORT_OUT(abort), .CRC_GEN_EN_OUT(crc),
        .PASS_THROUGH_EN_OUT(pen), .PASS_THROUGH_ALL_OUT(pall), .AUTO_ACK_OUT(ack),
        .PIXEL_STROBE_EDGE_SELECT_OUT(edg));
    lccr_link_model u_link (.clk_in(clk), .go_in(go), .lat_in(lat), .start_out(start),
        .done_out(done));
    ////////////////////////////////////////////////////////////////////////////////
    task check(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp) begin
            mismatches++;
            $display("Error t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task close_out;
        if (mismatches == 0 && tests_run > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    // Reserved bits forced to reset level
    task wr_reg(input logic [7:0] a, input logic [7:0] v);
        @(negedge clk) addr = a;
        wd = v;
        wr = 1;
        @(negedge clk) wr = 0;
        if (a inside {8'h03, 8'h04, 8'h05})
            regs[a] = (a == 8'h03) ? ((v & 8'h5D) | 8'hA0) : v;
    endtask
    task rd_chk(input logic [7:0] a);
        @(negedge clk) addr = a;
        rd = 1;
        @(negedge clk) rd = 0;
        check(rdata, (a inside {8'h03, 8'h04, 8'h05}) ? regs[a] : 8'h00);
    endtask
    task pulse(input int sel, input int len, input logic e);
        @(negedge clk) seen = 0;
        st[sel] = 1;
        for (int k = 0; k < len + 20; k++) begin
            @(negedge clk) seen = seen | {de_o, vs_o, ~sda_f, ~scl_f, hs_o};
            if (k == len - 1)
                st[sel] = 0;
        end
        if (sel == 0)
            check({5'h00, seen[4:3], seen[0]}, {5'h00, {3{e}}});
        else
            check({7'h00, seen[sel]}, {7'h00, e});
    endtask
    task kick(input logic [7:0] l);
        lat = l;
        go = 1;
        @(negedge clk) go = 0;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        void'($urandom(32'h30AE5FB7));
        regs[3] = 8'hF0;
        regs[4] = 8'hFE;
        regs[5] = 8'h2E;
        repeat (12) @(negedge clk);
        rst_n = 1;
        for (i = 2; i < 7; i++) rd_chk(i[7:0]);
        pulse(0, 1, 0);
        pulse(0, 2, 1);
        wr_reg(8'h03, 8'h00);
        pulse(0, 1, 1);
        wr_reg(8'h05, 8'h01);
        pulse(1, 1, 0);
        pulse(1, 3, 1);
        wr_reg(8'h05, 8'h11);
        pulse(2, 4, 0);
        pulse(2, 12, 1);
        wr_reg(8'h04, 8'h02);
        kick(8'h00);
        n = 0;
        while (abort !== 1'b1 && n < 40) begin
            @(negedge clk) n++;
        end
        if (n == 40) begin
            mismatches++;
            close_out;
        end
        check({7'h00, n >= 9 && n <= 14}, 8'h01);
        wr_reg(8'h04, 8'h03);
        kick(8'h00);
        repeat (30) @(negedge clk);
        check({7'h00, busy}, 8'h01);
        wr_reg(8'h04, 8'h04);
        kick(8'h03);
        repeat (8) @(negedge clk);
        check({6'h00, busy, abort}, 8'h00);
        for (i = 0; i < 30; i++) begin
            n = (i < 2) ? 3 : 2 + $urandom % 5;
            d = (i == 0) ? 8'hFF : (i == 1) ? 8'h00 : 8'($urandom);
            if (n == 4 && d[7:1] == 7'h00) d[1] = 1'b1;
            wr_reg(n[7:0], d);
            rd_chk(n[7:0]);
            check({3'h0, crc, pen, ack, edg, pall},
                {3'h0, regs[3][6], regs[3][3], regs[3][2], regs[3][0], regs[5][7]});
        end
        // Clock enable low freezes registers
        ce = 0;
        d = regs[5];
        wr_reg(8'h05, ~d);
        regs[5] = d;
        ce = 1;
        rd_chk(8'h05);
        check({7'h00, pall}, {7'h00, regs[5][7]});
        close_out;
    end
endmodule // tb_top
